// ==== core/seq_defs.svh ====
// Purpose: constants of the motion program sequencer
// Assumes: AXI4-Lite byte addresses in 8 bits, 32-bit data
// Notes: the list below describes what the sequencer does
// Function
// - User programs 0 to 89 share at most 1000 stored blocks.
// - Programs 90 to 99 are built in and cannot be overwritten.
// - Blocks count per statement; a statement plus trailing comment takes two.
// - With start-up enabled, program 0 runs at power-up; else it is ordinary.
// - Start without program number runs the stored execution program.
// - Without block number start at line 0 if program given, else stored line.
// - Step mode runs one line per start, then ends; a call line runs its whole subroutine first.
// - Auto-rewind restarts at line 0 after the last line.
// - Machine code 0 stops program operation unconditionally.
// - Machine code 1 stops operation only when optional stop is enabled.
// - Servo-ready and coordinate properties are checked before running; error if unmet.
// - After each positioning in a program, settle wait if enabled.
// - A program may call another stored program as a subroutine.
// - Signal search moves until the signal condition holds, then decelerates and stops.
// - Three search inputs, each enabled and set to detected or undetected.
// - Search stops when any enabled input reaches its configured state.
// - Search uses a trapezoid profile at the feed velocity.
// - After signal search completes, settle wait if enabled.
// - Immediate mode runs motion and parameter statements, rejects control and comments.
// - After an immediate positioning completes, settle wait if enabled.
`ifndef SEQ_DEFS_SVH
`define SEQ_DEFS_SVH
`define A_CTRL 8'h00
`define A_START 8'h04
`define A_STATUS 8'h08
`define A_POS 8'h0C
`define A_DIR 8'h10
`define A_BADDR 8'h14
`define A_BDATA 8'h18
`define A_IMM 8'h1C
`define A_FEED 8'h20
`define C_BOOT 0
`define C_STEP 1
`define C_REWIND 2
`define C_OPTSTOP 3
`define C_SETTLE 4
`define CTRL_RST 32'h0000_0001
`define FEED_RST 32'h0000_0100
`define ST_PGIVEN 31
`define ST_LGIVEN 30
`define D_VALID 31
`define D_SRV 29
`define D_CRD 28
`define STS_ERRCLR 1
`define USER_PROGS 7'd90
`define LAST_PROG 7'd99
`define BLOCK_CAP 11'd1000
`define BI_LEN 10'd1
`define MC_STOP 8'h00
`define MC_OPT 8'h01
`define DIR_W 22
`endif

// ==== core/seq_pkg.sv ====
// Purpose: types shared by the sequencer files
// Assumes: nothing
// Notes: op codes sit in bits 31:28 of each stored block
package seq_pkg;
	typedef enum logic [3:0] {S_IDLE = 4'h0, S_DIR_RD = 4'h1, S_DIR_CHK = 4'h2, S_FETCH = 4'h3,
		S_EXEC = 4'h4, S_MOVE_WT = 4'h5, S_SRCH_WT = 4'h6, S_SETTLE_WT = 4'h7,
		S_ADV = 4'h8} seq_state_e;
	typedef enum logic [3:0] {OP_NOP = 4'h0, OP_MOVE = 4'h1, OP_PARAM = 4'h2, OP_JUMP = 4'h3,
		OP_CALL = 4'h4, OP_MCODE = 4'h5, OP_COMMENT = 4'h6, OP_SEARCH = 4'h7} op_e;
	typedef enum logic [2:0] {E_NONE = 3'h0, E_UNREG = 3'h1, E_RANGE = 3'h2, E_PROP = 3'h3,
		E_IMM = 3'h4, E_NEST = 3'h5, E_WPROT = 3'h6, E_BUSY = 3'h7} err_e;
endpackage : seq_pkg

// ==== core/seq_ram.sv ====
// Purpose: simple dual-port memory for program blocks and directory
// Assumes: one write port, one read port, same clock
// Notes: read data is registered, one cycle after the address
`timescale 1ns/1ps
`default_nettype none
module seq_ram #(
	parameter int W = 32,
	parameter int D = 1000,
	parameter int AW = 10
) (
	input wire logic clk,
	input wire logic we,
	input wire logic [AW-1:0] wa,
	input wire logic [W-1:0] wd,
	input wire logic [AW-1:0] ra,
	output logic [W-1:0] rd
);
	logic [W-1:0] mem [0:D-1];

	// Write then registered read
	always_ff @(posedge clk) begin
		if (we) begin
			mem[wa] <= wd;
		end
		rd <= mem[ra];
	end
endmodule : seq_ram
`default_nettype wire

// ==== core/search_watch.sv ====
// Purpose: synchronise the sensor pins and detect the search condition
// Assumes: pins are asynchronous to clk
// Notes: hit is a level from the second sync stage
`timescale 1ns/1ps
`default_nettype none
module search_watch (
	input wire logic clk,
	input wire logic nrst,
	input wire logic ot_pos,
	input wire logic ot_neg,
	input wire logic home_prox,
	input wire logic servo_rdy,
	input wire logic coord_set,
	input wire logic [2:0] srch_en,
	input wire logic [2:0] srch_pol,
	output logic servo_ok,
	output logic coord_ok,
	output logic hit
);
	logic [4:0] raw;
	logic [4:0] s1_q;
	logic [4:0] s2_q;

	assign raw = {coord_set, servo_rdy, home_prox, ot_neg, ot_pos};

	// Two-stage synchroniser per pin
	genvar i;
	for (i = 0; i < 5; i++) begin : g_sync
		always_ff @(posedge clk or negedge nrst) begin
			if (!nrst) begin
				s1_q[i] <= 1'b0;
				s2_q[i] <= 1'b0;
			end else begin
				s1_q[i] <= raw[i];
				s2_q[i] <= s1_q[i];
			end
		end
	end

	assign servo_ok = s2_q[3];
	assign coord_ok = s2_q[4];
	// any enabled input at its level
	assign hit = |(srch_en & ~(s2_q[2:0] ^ srch_pol));
endmodule : search_watch
`default_nettype wire

// ==== core/motion_program_sequencer.sv ====
// Purpose: runs stored programs, immediate statements and signal searches
// Assumes: move_done and settle_done come from logic on clk
// Notes: one subroutine level; built-in programs are constant single searches
`timescale 1ns/1ps
`default_nettype none
`include "seq_defs.svh"
module motion_program_sequencer
	import seq_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [7:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	input wire logic ot_pos,
	input wire logic ot_neg,
	input wire logic home_prox,
	input wire logic servo_rdy,
	input wire logic coord_set,
	input wire logic move_done,
	input wire logic settle_done,
	output logic move_req,
	output logic [27:0] move_target,
	output logic search_req,
	output logic search_stop,
	output logic search_dir,
	output logic search_trap,
	output logic [31:0] search_vel,
	output logic settle_req,
	output logic param_wr,
	output logic [27:0] param_word,
	output logic mcode_strobe,
	output logic [7:0] mcode,
	output logic busy
);
	seq_state_e state_q;
	logic [31:0] ctrl_q, feed_q, imm_word_q;
	logic aw_q, w_q, bvalid_q, rvalid_q, wr_fire;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q, rdata_q, rd_mux;
	logic [3:0] wstrb_q;
	logic [1:0] bresp_q, rresp_q;
	logic [127:0] valid_q;
	logic [9:0] blk_wa_q, blk_ra, line_q, len_q, base_q, nx, exec_line_q;
	logic [9:0] ret_line_q, ret_len_q, ret_base_q, jline_q;
	logic [6:0] prog_q, exec_prog_q, ret_prog_q;
	logic [31:0] blk_rd, word;
	logic [`DIR_W-1:0] dir_rd;
	logic blk_we, dir_we, bus_err, fsm_err_q, err_q, boot_q;
	err_e bus_code, fsm_code_q, err_code_q;
	logic imm_q, in_call_q, jump_q, stop_q, stopped_q, wrap;
	logic [6:0] srch_cfg_q;
	logic servo_ok, coord_ok, hit;
	logic user, e_valid, e_srv, e_crd;
	logic [9:0] e_len, e_base;
	op_e op;
	logic [27:0] arg;

	// Byte-lane merge for plain storage registers
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				r[b*8 +: 8] = n[b*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	// Address decode shared by reads and writes
	function automatic logic mapped(input logic [7:0] a);
		case (a)
			`A_CTRL, `A_START, `A_STATUS, `A_POS, `A_DIR, `A_BADDR, `A_BDATA, `A_IMM,
			`A_FEED: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	endfunction : mapped

	// built-in programs are fixed single searches
	function automatic logic [31:0] builtin_word(input logic [6:0] p);
		logic [6:0] k;
		k = 7'(p - `USER_PROGS);
		return {OP_SEARCH, 21'h0, k[3], k[2:0], 3'h7};
	endfunction : builtin_word

	// AXI4-Lite channel handshakes
	assign s_axi_awready = !aw_q;
	assign s_axi_wready = !w_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign wr_fire = aw_q && w_q && !bvalid_q;

	// Hold address and data until both present
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end else begin
			if (s_axi_awvalid && !aw_q) begin
				aw_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_q <= 1'b0;
			end
			if (s_axi_wvalid && !w_q) begin
				w_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_q <= 1'b0;
			end
		end
	end

	// Write and read responses
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			bvalid_q <= 1'b0;
			bresp_q <= 2'h0;
			rvalid_q <= 1'b0;
			rresp_q <= 2'h0;
			rdata_q <= 32'h0000_0000;
		end else begin
			if (wr_fire) begin
				bvalid_q <= 1'b1;
				bresp_q <= mapped(awaddr_q) ? 2'h0 : 2'h2;
			end else if (s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
			if (s_axi_arvalid && !rvalid_q) begin
				rvalid_q <= 1'b1;
				rdata_q <= rd_mux;
				rresp_q <= mapped(s_axi_araddr) ? 2'h0 : 2'h2;
			end else if (s_axi_rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	// Read data selection
	always_comb begin
		case (s_axi_araddr)
			`A_CTRL: rd_mux = ctrl_q;
			`A_STATUS: rd_mux = {18'h0, imm_q, in_call_q, state_q, 1'b0, err_code_q, 2'h0,
				err_q, busy};
			`A_POS: rd_mux = {9'h0, exec_prog_q, 6'h0, exec_line_q};
			`A_BADDR: rd_mux = {22'h0, blk_wa_q};
			`A_FEED: rd_mux = feed_q;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Settings and feed velocity
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_q <= `CTRL_RST;
			feed_q <= `FEED_RST;
		end else if (wr_fire) begin
			if (awaddr_q == `A_CTRL) begin
				ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q) & 32'h0000_001F;
			end
			if (awaddr_q == `A_FEED) begin
				feed_q <= merge(feed_q, wdata_q, wstrb_q);
			end
		end
	end

	assign blk_we = wr_fire && awaddr_q == `A_BDATA && {1'b0, blk_wa_q} < `BLOCK_CAP;
	// directory refuses built-in numbers and overflow
	assign dir_we = wr_fire && awaddr_q == `A_DIR && wdata_q[26:20] < `USER_PROGS &&
		({1'b0, wdata_q[19:10]} + {1'b0, wdata_q[9:0]}) <= `BLOCK_CAP;
	assign bus_err = wr_fire && ((awaddr_q == `A_DIR && !dir_we) ||
		(awaddr_q == `A_BDATA && !blk_we));
	assign bus_code = (awaddr_q == `A_DIR) ? E_WPROT : E_RANGE;

	// Block address pointer and registered programs
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			blk_wa_q <= 10'h000;
			valid_q <= '0;
		end else begin
			if (wr_fire && awaddr_q == `A_BADDR) begin
				blk_wa_q <= wdata_q[9:0];
			end else if (wr_fire && awaddr_q == `A_BDATA) begin
				blk_wa_q <= 10'(blk_wa_q + 10'h001);
			end
			if (dir_we) begin
				valid_q[wdata_q[26:20]] <= wdata_q[`D_VALID];
			end
		end
	end

	// Error flag: a new error wins over a clear
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			err_q <= 1'b0;
			err_code_q <= E_NONE;
		end else if (fsm_err_q || bus_err) begin
			err_q <= 1'b1;
			err_code_q <= fsm_err_q ? fsm_code_q : bus_code;
		end else if (wr_fire && awaddr_q == `A_STATUS && wdata_q[`STS_ERRCLR]) begin
			err_q <= 1'b0;
			err_code_q <= E_NONE;
		end
	end

	seq_ram #(.W(32), .D(1000), .AW(10)) u_blocks (
		.clk(clk), .we(blk_we), .wa(blk_wa_q), .wd(wdata_q), .ra(blk_ra), .rd(blk_rd)
	);
	seq_ram #(.W(`DIR_W), .D(90), .AW(7)) u_dir (
		.clk(clk), .we(dir_we), .wa(wdata_q[26:20]),
		.wd({wdata_q[`D_SRV], wdata_q[`D_CRD], wdata_q[19:0]}), .ra(prog_q), .rd(dir_rd)
	);
	search_watch u_watch (
		.clk(clk), .nrst(nrst), .ot_pos(ot_pos), .ot_neg(ot_neg), .home_prox(home_prox),
		.servo_rdy(servo_rdy), .coord_set(coord_set), .srch_en(srch_cfg_q[2:0]),
		.srch_pol(srch_cfg_q[5:3]), .servo_ok(servo_ok), .coord_ok(coord_ok), .hit(hit)
	);

	// Directory entry, current statement and next line
	assign user = prog_q < `USER_PROGS;
	assign e_valid = user ? valid_q[prog_q] : (prog_q <= `LAST_PROG);
	assign e_len = user ? dir_rd[9:0] : `BI_LEN;
	assign e_base = user ? dir_rd[19:10] : 10'h000;
	assign e_srv = user && dir_rd[21];
	assign e_crd = user && dir_rd[20];
	assign blk_ra = 10'(base_q + line_q);
	assign word = imm_q ? imm_word_q : (user ? blk_rd : builtin_word(prog_q));
	assign op = op_e'(word[31:28]);
	assign arg = word[27:0];
	assign nx = jump_q ? jline_q : 10'(line_q + 10'h001);
	assign wrap = nx >= len_q;
	assign busy = state_q != S_IDLE;
	assign search_vel = feed_q;
	assign search_dir = srch_cfg_q[6];

	// Sequencer
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= S_IDLE;
			{move_req, search_req, search_stop, settle_req, param_wr, mcode_strobe} <= 6'h00;
			{fsm_err_q, imm_q, in_call_q, jump_q, stop_q, stopped_q, search_trap} <= 7'h00;
			boot_q <= 1'b1;
			fsm_code_q <= E_NONE;
			move_target <= 28'h0000000;
			param_word <= 28'h0000000;
			mcode <= 8'h00;
			imm_word_q <= 32'h0000_0000;
			{prog_q, exec_prog_q, ret_prog_q} <= 21'h000000;
			{line_q, len_q, base_q, exec_line_q, jline_q} <= 50'h0;
			{ret_line_q, ret_len_q, ret_base_q} <= 30'h0;
			srch_cfg_q <= 7'h00;
		end else begin
			{move_req, search_req, search_stop, settle_req, param_wr, mcode_strobe} <= 6'h00;
			fsm_err_q <= 1'b0;
			if (state_q != S_IDLE && wr_fire && (awaddr_q == `A_START || awaddr_q == `A_IMM)) begin
				fsm_err_q <= 1'b1;
				fsm_code_q <= E_BUSY;
			end
			case (state_q)
				S_IDLE: begin
					{in_call_q, jump_q, stop_q, imm_q} <= 4'h0;
					boot_q <= 1'b0;
					if (boot_q && ctrl_q[`C_BOOT]) begin
						prog_q <= 7'h00;
						line_q <= 10'h000;
						state_q <= S_DIR_RD;
					end else if (wr_fire && awaddr_q == `A_START) begin
						// stored program unless one is given
						prog_q <= wdata_q[`ST_PGIVEN] ? wdata_q[22:16] : exec_prog_q;
						// given line, else top or stored line
						line_q <= wdata_q[`ST_LGIVEN] ? wdata_q[9:0] :
							(wdata_q[`ST_PGIVEN] ? 10'h000 : exec_line_q);
						state_q <= S_DIR_RD;
					end else if (wr_fire && awaddr_q == `A_IMM) begin
						imm_q <= 1'b1;
						imm_word_q <= wdata_q;
						state_q <= S_EXEC;
					end else if (wr_fire && awaddr_q == `A_POS) begin
						exec_prog_q <= wdata_q[22:16];
						exec_line_q <= wdata_q[9:0];
					end
				end
				S_DIR_RD: state_q <= S_DIR_CHK;
				S_DIR_CHK: begin
					state_q <= S_IDLE;
					fsm_err_q <= 1'b1;
					if (!e_valid) begin
						fsm_code_q <= E_UNREG;
					end else if (line_q >= e_len) begin
						fsm_code_q <= E_RANGE;
					end else if ((e_srv && !servo_ok) || (e_crd && !coord_ok)) begin
						fsm_code_q <= E_PROP;
					end else begin
						fsm_err_q <= 1'b0;
						base_q <= e_base;
						len_q <= e_len;
						state_q <= S_FETCH;
					end
				end
				S_FETCH: begin
					jump_q <= 1'b0;
					state_q <= S_EXEC;
				end
				S_EXEC: begin
					state_q <= S_ADV;
					case (op)
						OP_MOVE: begin
							move_req <= 1'b1;
							move_target <= arg;
							state_q <= S_MOVE_WT;
						end
						OP_SEARCH: begin
							search_req <= 1'b1;
							search_trap <= 1'b1;
							stopped_q <= 1'b0;
							srch_cfg_q <= arg[6:0];
							state_q <= S_SRCH_WT;
						end
						OP_PARAM: begin
							param_wr <= 1'b1;
							param_word <= arg;
						end
						OP_MCODE: begin
							mcode_strobe <= 1'b1;
							mcode <= arg[7:0];
							stop_q <= arg[7:0] == `MC_STOP ||
								(arg[7:0] == `MC_OPT && ctrl_q[`C_OPTSTOP]);
						end
						OP_JUMP, OP_CALL, OP_COMMENT: begin
							if (imm_q) begin
								fsm_err_q <= 1'b1;
								fsm_code_q <= E_IMM;
								state_q <= S_IDLE;
							end else if (op == OP_JUMP) begin
								jump_q <= 1'b1;
								jline_q <= arg[9:0];
								if (arg[9:0] >= len_q) begin
									fsm_err_q <= 1'b1;
									fsm_code_q <= E_RANGE;
									state_q <= S_IDLE;
								end
							end else if (op == OP_CALL) begin
								if (in_call_q) begin
									fsm_err_q <= 1'b1;
									fsm_code_q <= E_NEST;
									state_q <= S_IDLE;
								end else begin
									{ret_prog_q, ret_line_q} <= {prog_q, line_q};
									{ret_base_q, ret_len_q} <= {base_q, len_q};
									in_call_q <= 1'b1;
									prog_q <= arg[6:0];
									line_q <= 10'h000;
									state_q <= S_DIR_RD;
								end
							end
							// a comment holds its own block and is skipped
						end
						default: state_q <= S_ADV;
					endcase
				end
				S_SRCH_WT, S_MOVE_WT: begin
					if (state_q == S_SRCH_WT && hit && !stopped_q) begin
						// first matching input ends the search
						search_stop <= 1'b1;
						stopped_q <= 1'b1;
					end
					if (move_done) begin
						search_trap <= 1'b0;
						settle_req <= ctrl_q[`C_SETTLE];
						state_q <= ctrl_q[`C_SETTLE] ? S_SETTLE_WT : S_ADV;
					end
				end
				S_SETTLE_WT: state_q <= settle_done ? S_ADV : S_SETTLE_WT;
				S_ADV: begin
					if (imm_q) begin
						state_q <= S_IDLE;
					end else if (in_call_q && wrap && !stop_q) begin
						// Return to the caller's call line
						{prog_q, line_q} <= {ret_prog_q, ret_line_q};
						{base_q, len_q} <= {ret_base_q, ret_len_q};
						{in_call_q, jump_q} <= 2'h0;
					end else if (stop_q || (wrap && !ctrl_q[`C_REWIND]) ||
						(ctrl_q[`C_STEP] && !in_call_q)) begin
						exec_prog_q <= prog_q;
						exec_line_q <= wrap ? 10'h000 : nx;
						state_q <= S_IDLE;
					end else begin
						line_q <= wrap ? 10'h000 : nx;
						state_q <= S_FETCH;
					end
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end

	a_blk_cap:
	assert property (@(posedge clk) disable iff (!nrst)
		wr_fire && awaddr_q == `A_BDATA && {1'b0, blk_wa_q} >= `BLOCK_CAP |-> !blk_we ##1 err_q)
		else $error("block write beyond capacity not refused");
	a_dir_protect:
	assert property (@(posedge clk) disable iff (!nrst)
		wr_fire && awaddr_q == `A_DIR && wdata_q[26:20] >= `USER_PROGS |=> err_q)
		else $error("built-in directory write not refused");
	a_m0_stop:
	assert property (@(posedge clk) disable iff (!nrst)
		state_q == S_EXEC && op == OP_MCODE && arg[7:0] == `MC_STOP |=> ##1 state_q == S_IDLE)
		else $error("machine code zero did not stop");
	a_prop_check:
	assert property (@(posedge clk) disable iff (!nrst)
		state_q == S_DIR_CHK && e_valid && e_srv && !servo_ok |=> state_q == S_IDLE && fsm_err_q
		##1 err_q) else $error("servo-ready property not enforced");
	a_move_settle:
	assert property (@(posedge clk) disable iff (!nrst)
		state_q == S_MOVE_WT && move_done && ctrl_q[`C_SETTLE] |=> settle_req && !move_req)
		else $error("settle not requested after positioning");
	a_search_stop:
	assert property (@(posedge clk) disable iff (!nrst)
		state_q == S_SRCH_WT && hit && !stopped_q |=> search_stop ##1 !search_stop)
		else $error("search stop not a single pulse on hit");
	a_imm_reject:
	assert property (@(posedge clk) disable iff (!nrst)
		state_q == S_EXEC && imm_q && (op == OP_JUMP || op == OP_COMMENT) |=>
		state_q == S_IDLE && !move_req) else $error("immediate control statement not rejected");
	a_step_one:
	assert property (@(posedge clk) disable iff (!nrst)
		state_q == S_ADV && ctrl_q[`C_STEP] && !in_call_q && !imm_q |=> state_q == S_IDLE)
		else $error("step mode ran past one line");
endmodule : motion_program_sequencer
`default_nettype wire

// ==== bench/motion_partner.sv ====
// Purpose: far-side model answering moves, searches and settle waits
// Assumes: requests are one-cycle pulses on clk
// Notes: answers come a fixed DLY cycles after each request
`timescale 1ns/1ps
`default_nettype none
module motion_partner #(
	parameter int DLY = 8
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic move_req,
	input wire logic search_stop,
	input wire logic settle_req,
	output logic move_done,
	output logic settle_done
);
	logic [7:0] mv_q;
	logic [7:0] st_q;
	// Count down from each request; a search ends only after its stop
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mv_q <= 8'h00;
			st_q <= 8'h00;
		end else begin
			mv_q <= (move_req || search_stop) ? 8'(DLY) : (mv_q != 8'h00 ? mv_q - 8'h01 : mv_q);
			st_q <= settle_req ? 8'(DLY) : (st_q != 8'h00 ? st_q - 8'h01 : st_q);
		end
	end
	// Done pulses last one cycle
	assign move_done = (mv_q == 8'h01);
	assign settle_done = (st_q == 8'h01);
endmodule : motion_partner
`default_nettype wire

// ==== bench/motion_program_sequencer_tb.sv ====
// Purpose: self-checking bench for the motion program sequencer
// Assumes: bready and rready stay high, so answers are taken at once
// Notes: program 5 is lines 0..2, program 6 needs servo ready
`timescale 1ns/1ps
`default_nettype none
module motion_program_sequencer_tb;
	logic clk = 0, nrst = 0, awv = 0, wv = 0, arv = 0, srdy = 0, crd = 0;
	logic [2:0] pin = 3'h0;
	logic [7:0] awa = 8'h00, ara = 8'h00, mc;
	logic [31:0] wd = 32'h0, rdat, d, sv;
	logic awr, wrd, bv, arr, rv, mreq, sstop, sreq, mdone, sdone, busy, strp, sdir;
	logic [1:0] bresp, rresp, rr;
	logic [27:0] mtgt, pw;
	int bad_count = 0, n_tests = 0, n_settle = 0, n_stop = 0;
	// Clock of 4 ns
	always #2 clk = ~clk;
	always @(posedge clk) if (sreq) n_settle++;
	always @(posedge clk) if (sstop) n_stop++;
	motion_program_sequencer dut (.clk(clk), .nrst(nrst), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wrd),
		.s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(1'b1),
		.s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
		.s_axi_rvalid(rv), .s_axi_rready(1'b1), .s_axi_rdata(rdat), .s_axi_rresp(rresp),
		.ot_pos(pin[0]), .ot_neg(pin[1]), .home_prox(pin[2]), .servo_rdy(srdy),
		.coord_set(crd), .move_done(mdone), .settle_done(sdone), .move_req(mreq),
		.move_target(mtgt), .search_req(), .search_stop(sstop), .search_dir(sdir),
		.search_trap(strp), .search_vel(sv), .settle_req(sreq), .param_wr(), .param_word(pw),
		.mcode_strobe(), .mcode(mc), .busy(busy));
	motion_partner part (.clk(clk), .nrst(nrst), .move_req(mreq), .search_stop(sstop),
		.settle_req(sreq), .move_done(mdone), .settle_done(sdone));
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// Write: address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		awa <= a;
		wd <= v;
		awv <= 1'b1;
		wv <= 1'b1;
		do begin
			@(posedge clk);
			if (awv && awr) awv <= 1'b0;
			if (wv && wrd) wv <= 1'b0;
		end while (!bv);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		ara <= a;
		arv <= 1'b1;
		do begin
			@(posedge clk);
			if (arv && arr) arv <= 1'b0;
		end while (!rv);
		d = rdat;
		rr = rresp;
	endtask : rd
	task automatic idle;
		repeat (3) @(posedge clk);
		while (busy !== 1'b0) @(posedge clk);
	endtask : idle
	// Error code and flag, then clear
	task automatic err(input logic [2:0] code);
		idle;
		rd(8'h08);
		chk("err", d & 32'h72, {25'h0, code, 4'h2});
		wr(8'h08, 32'h2);
	endtask : err
	task automatic prog(input logic [31:0] st, input logic [27:0] tgt, input logic [31:0] pos);
		wr(8'h04, st);
		idle;
		chk("target", {4'h0, mtgt}, {4'h0, tgt});
		rd(8'h0C);
		chk("pos", d, pos);
	endtask : prog
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : wrap_up
	initial begin
		repeat (25000) @(posedge clk);
		bad_count++;
		wrap_up;
	end
	initial begin
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		idle;
		err(3'h1);
		rd(8'h00);
		chk("ctrl", d, 32'h1);
		rd(8'h20);
		chk("feed", d, 32'h100);
		rd(8'h40);
		chk("unmapped", {d[31:2], rr}, 32'h2);
		wr(8'h10, 32'h85A0_0001);
		err(3'h6);
		wr(8'h14, 32'h3E8);
		wr(8'h18, 32'h0);
		err(3'h2);
		wr(8'h14, 32'h0);
		wr(8'h18, 32'h1000_0123);
		wr(8'h18, 32'h5000_0000);
		wr(8'h18, 32'h1000_0456);
		wr(8'h18, 32'h1000_0001);
		wr(8'h18, 32'h4000_0005);
		wr(8'h10, 32'h8050_0003);
		wr(8'h10, 32'hA060_0C01);
		wr(8'h10, 32'h8080_1001);
		wr(8'h04, 32'h8007_0000);
		idle;
		err(3'h1);
		wr(8'h04, 32'h8006_0000);
		idle;
		err(3'h3);
		prog(32'h8005_0000, 28'h123, 32'h0005_0002);
		chk("mcode", {24'h0, mc}, 32'h0);
		prog(32'h0, 28'h456, 32'h0005_0000);
		prog(32'h8008_0000, 28'h123, 32'h0005_0002);
		wr(8'h00, 32'h12);
		prog(32'h8005_0000, 28'h123, 32'h0005_0001);
		chk("settle", n_settle, 1);
		prog(32'h0, 28'h123, 32'h0005_0002);
		wr(8'h00, 32'h4);
		prog(32'h0, 28'h123, 32'h0005_0002);
		wr(8'h00, 32'h10);
		wr(8'h1C, 32'h3000_0000);
		err(3'h4);
		wr(8'h1C, 32'h1000_0077);
		idle;
		chk("imm", {4'h0, mtgt}, 32'h77);
		chk("settle", n_settle, 2);
		wr(8'h1C, 32'h2000_0ABC);
		idle;
		chk("param", {4'h0, pw}, 32'hABC);
		pin <= 3'h7;
		wr(8'h04, 32'h805A_0000);
		repeat (20) @(posedge clk);
		chk("srch busy", {31'h0, busy}, 32'h1);
		chk("early stop", n_stop, 0);
		chk("trap", {31'h0, strp}, 32'h1);
		chk("vel", sv, 32'h100);
		chk("dir", {31'h0, sdir}, 32'h0);
		pin <= 3'h3;
		idle;
		chk("stop", n_stop, 1);
		chk("trap end", {31'h0, strp}, 32'h0);
		chk("settle", n_settle, 3);
		rd(8'h0C);
		chk("srch pos", d, 32'h005A_0000);
		wrap_up;
	end
endmodule : motion_program_sequencer_tb
`default_nettype wire
